/* File: txc_pkg.sv */
// Package for the transmit control and FIFO configuration block.
// Assumes a single core clock; shared by the design and its testbench.
`default_nettype none

package txc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0]  TXC_TX_CTRL_OFS   = 8'h70;
  localparam logic [7:0]  TXC_HARDWARE_CONFIGURATION_OFS    = 8'h74;
  localparam logic [7:0]  TXC_INT_STS_OFS   = 8'h78;
  localparam logic [7:0]  TXC_INT_MSK_OFS   = 8'h7c;
  localparam logic [7:0]  TXC_ALLOC_OFS     = 8'h80;

  // Transmit control bit positions
  localparam int          TXC_STOP_BIT      = 0;
  localparam int          TXC_ENABLE_BIT    = 1;
  localparam int          TXC_OVR_BIT       = 2;
  localparam int          TXC_DDISC_BIT     = 14;
  localparam int          TXC_SDISC_BIT     = 15;

  // Hardware configuration field positions
  localparam int          TXC_SIZE_LSB      = 16;
  localparam int          TXC_BWF_BIT       = 20;
  localparam int          TXC_TMODE_BIT     = 21;
  localparam int          TXC_STRAP_BIT     = 24;

  // Start level code position (threshold code sits in transmit control)
  localparam int          TXC_LVL_LSB       = 12;

  // Interrupt status bit positions
  localparam int          TXC_IRQ_SFULL     = 0;
  localparam int          TXC_IRQ_UNDER     = 1;
  localparam int          TXC_IRQ_HALT      = 2;

  // Reset values
  localparam logic [3:0]  TXC_SIZE_RST      = 4'h5;
  localparam logic [2:0]  TXC_MSK_RST       = 3'h0;

  // Memory split, in bytes
  localparam logic [14:0] TXC_TOTAL_BYTES   = 15'h4000;
  localparam logic [14:0] TXC_STS_BYTES     = 15'h0200;

  // Start levels in DWORDs for the 10 Mbit/s table
  localparam logic [7:0]  TXC_LVL0          = 8'h12;
  localparam logic [7:0]  TXC_LVL1          = 8'h18;
  localparam logic [7:0]  TXC_LVL2          = 8'h20;
  localparam logic [7:0]  TXC_LVL3          = 8'h28;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } txc_bus_req_t;

  // Engine status toward the block
  typedef struct packed {
    logic       halted;
    logic       sts_full;
    logic       underrun;
    logic [7:0] data_dwords;
    logic       frame_whole;
  } txc_eng_t;

  // Controls toward the engine
  typedef struct packed {
    logic        run;
    logic        stop_req;
    logic        go;
    logic        sdiscard;
    logic        ddiscard;
    logic [14:0] tx_bytes;
    logic [14:0] txd_bytes;
    logic [14:0] rx_bytes;
  } txc_ctl_t;

endpackage : txc_pkg

`default_nettype wire

/* File: txc_ctrl.sv */
// Transmit control and TX/RX FIFO memory configuration registers.
// Assumes a host register port on i_core_clk and a transmit engine on
// the same clock; the crossover strap arrives asynchronously from a pin.
//
// Function
// - Status discard bit flushes status, self-clears
// - Data discard bit flushes data, self-clears
// - Full status FIFO suspends unless overrun allowed
// - Status-full interrupt independent of overrun allow
// - Enable bit makes transmitter send FIFO data
// - Enable auto-clears once stopped after request
// - Stop request finishes frame, clears when halted
// - Writes to stop bit ignored while set
// - Bit 24 reads sampled crossover strap
// - Threshold mode picks table, ignored when buffering
// - Whole-frame buffering waits for complete frame
// - Threshold start otherwise, underrun flagged
// - FIFO size in KB, resets to five
// - 512 bytes status, rest data FIFO
// - RX gets 16KB minus TX allocation
// - Threshold code selects 12h/18h/20h/28h DWORDs
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module txc_ctrl
  import txc_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_srst,
  // Register port
  input  wire txc_pkg::txc_bus_req_t i_bus,
  output logic [31:0]                o_rdata,
  // Strap pin
  input  wire logic                  i_crossover_strap,
  // Transmit engine
  input  wire txc_pkg::txc_eng_t     i_eng,
  output txc_pkg::txc_ctl_t          o_ctl,
  // Interrupt
  output logic                       o_irq
);
  import txc_pkg::*;

  // Transmit control fields
  logic        stop_r;
  logic        stop_nxt;
  logic        enable_r;
  logic        enable_nxt;
  logic        ovr_r;
  logic [1:0]  lvl_r;

  // Hardware configuration fields
  logic        tmode_r;
  logic        bwf_r;
  logic [3:0]  size_r;

  // Strap synchroniser
  logic        strap_s1_r;
  logic        strap_s2_r;

  // Interrupt state
  logic [2:0]  sts_r;
  logic [2:0]  sts_nxt;
  logic [2:0]  msk_r;
  logic        sfull_d_r;
  logic        halt_d_r;
  logic [2:0]  ev;

  // Bus decode
  logic        wr_ctrl;
  logic        wr_hw;
  logic        wr_msk;
  logic        rd_sts;

  // Start decision and memory split
  logic [7:0]  level;
  logic        start_ok;
  logic        stopped;
  logic [14:0] tx_bytes;
  logic [14:0] txd_bytes;
  logic [14:0] rx_bytes;

  // Register images and engine controls
  logic [31:0] ctrl_word;
  logic [31:0] hw_word;
  logic [31:0] alloc_word;
  logic [31:0] rdata_nxt;
  txc_ctl_t    ctl_nxt;

  // Start level lookup, 10 Mbit/s table
  function automatic logic [7:0] txc_level(input logic [1:0] code);
    unique case (code)
      2'h0: txc_level = TXC_LVL0;
      2'h1: txc_level = TXC_LVL1;
      2'h2: txc_level = TXC_LVL2;
      default: txc_level = TXC_LVL3;
    endcase
  endfunction : txc_level

  // KB count to bytes
  function automatic logic [14:0] txc_kb(input logic [3:0] kb);
    txc_kb = {1'b0, kb, 10'h000};
  endfunction : txc_kb

  // Address match against a register offset
  function automatic logic txc_hit(input logic [7:0] addr, input logic [7:0] ofs);
    txc_hit = (addr == ofs);
  endfunction : txc_hit

  assign wr_ctrl = i_bus.wr && txc_hit(i_bus.addr, TXC_TX_CTRL_OFS);
  assign wr_hw   = i_bus.wr && txc_hit(i_bus.addr, TXC_HARDWARE_CONFIGURATION_OFS);
  assign wr_msk  = i_bus.wr && txc_hit(i_bus.addr, TXC_INT_MSK_OFS);
  assign rd_sts  = i_bus.rd && txc_hit(i_bus.addr, TXC_INT_STS_OFS);
  assign stopped = stop_r && i_eng.halted;

  // Strap synchroniser, first stage; only the second stage is read
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      strap_s1_r <= 1'b0;
    else
      strap_s1_r <= i_crossover_strap;
  end

  // Strap synchroniser, second stage
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      strap_s2_r <= 1'b0;
    else
      strap_s2_r <= strap_s1_r;
  end

  // Stop request; a write cannot drop it while set
  always_comb
  begin
    stop_nxt = stop_r;
    if (stopped)
      stop_nxt = 1'b0;
    else if (wr_ctrl && !stop_r)
      stop_nxt = i_bus.wdata[TXC_STOP_BIT];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      stop_r <= 1'b0;
    else
      stop_r <= stop_nxt;
  end

  // Enable; halt completion wins over a racing write
  always_comb
  begin
    enable_nxt = enable_r;
    if (stopped)
      enable_nxt = 1'b0;
    else if (wr_ctrl)
      enable_nxt = i_bus.wdata[TXC_ENABLE_BIT];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      enable_r <= 1'b0;
    else
      enable_r <= enable_nxt;
  end

  // Overrun allow
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      ovr_r <= 1'b0;
    else if (wr_ctrl)
      ovr_r <= i_bus.wdata[TXC_OVR_BIT];
  end

  // Start level code, consulted only in threshold mode
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      lvl_r <= 2'h0;
    else if (wr_ctrl)
      lvl_r <= i_bus.wdata[TXC_LVL_LSB +: 2];
  end

  // Hardware configuration below; no interlock against a running engine,
  // so a write while TX or RX runs takes effect at once
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      tmode_r <= 1'b0;
    else if (wr_hw)
      tmode_r <= i_bus.wdata[TXC_TMODE_BIT];
  end

  // Whole-frame buffering
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      bwf_r <= 1'b0;
    else if (wr_hw)
      bwf_r <= i_bus.wdata[TXC_BWF_BIT];
  end

  // FIFO size; out-of-range values are the host's to avoid
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      size_r <= TXC_SIZE_RST;
    else if (wr_hw)
      size_r <= i_bus.wdata[TXC_SIZE_LSB +: 4];
  end

  // Start level for the 10 Mbit/s table
  always_comb
  begin
    level = txc_level(lvl_r);
  end

  // Start decision
  always_comb
  begin
    if (bwf_r)
      start_ok = i_eng.frame_whole;
    else if (tmode_r)
      start_ok = i_eng.data_dwords >= level;
    else
      // 100 Mbit/s table lies outside this block; start on any data
      start_ok = i_eng.data_dwords != 8'h00;
  end

  // Memory split, shared by the engine controls and the read mux
  always_comb
  begin
    tx_bytes  = txc_kb(size_r);
    txd_bytes = 15'(tx_bytes - TXC_STS_BYTES);
    rx_bytes  = 15'(TXC_TOTAL_BYTES - tx_bytes);
  end

  // Engine controls; the status-full gate applies only without overrun allow
  always_comb
  begin
    ctl_nxt           = '0;
    ctl_nxt.run       = enable_r && (ovr_r || !i_eng.sts_full);
    ctl_nxt.stop_req  = stop_r;
    ctl_nxt.go        = start_ok;
    ctl_nxt.sdiscard  = wr_ctrl && i_bus.wdata[TXC_SDISC_BIT];
    ctl_nxt.ddiscard  = wr_ctrl && i_bus.wdata[TXC_DDISC_BIT];
    ctl_nxt.tx_bytes  = tx_bytes;
    ctl_nxt.txd_bytes = txd_bytes;
    ctl_nxt.rx_bytes  = rx_bytes;
  end

  // Registered so every engine control leaves a flop
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_ctl <= '0;
    else
      o_ctl <= ctl_nxt;
  end

  // Interrupt events: status-full and halt on rising edges; underrun is a level, gated off while buffering whole frames
  always_comb
  begin
    ev                = 3'h0;
    ev[TXC_IRQ_SFULL] = i_eng.sts_full && !sfull_d_r;
    ev[TXC_IRQ_UNDER] = i_eng.underrun && !bwf_r;
    ev[TXC_IRQ_HALT]  = stopped && !halt_d_r;
  end

  // Edge history; both idle low out of reset, so no false edge follows it
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      sfull_d_r <= 1'b0;
    else
      sfull_d_r <= i_eng.sts_full;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      halt_d_r <= 1'b0;
    else
      halt_d_r <= stopped;
  end

  // New event wins over the clearing read, so none is lost
  always_comb
  begin
    sts_nxt = (rd_sts ? 3'h0 : sts_r) | ev;
  end

  // Sticky status
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      sts_r <= 3'h0;
    else
      sts_r <= sts_nxt;
  end

  // Interrupt mask
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      msk_r <= TXC_MSK_RST;
    else if (wr_msk)
      msk_r <= i_bus.wdata[2:0];
  end

  // Level output from the next status, so it rises with the event
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_irq <= 1'b0;
    else
      o_irq <= |(sts_nxt & msk_r);
  end

  // Register images; discard bits are pulses and always read zero
  always_comb
  begin
    ctrl_word                   = 32'h0000_0000;
    ctrl_word[TXC_STOP_BIT]     = stop_r;
    ctrl_word[TXC_ENABLE_BIT]   = enable_r;
    ctrl_word[TXC_OVR_BIT]      = ovr_r;
    ctrl_word[TXC_LVL_LSB +: 2] = lvl_r;
  end

  always_comb
  begin
    hw_word                     = 32'h0000_0000;
    hw_word[TXC_STRAP_BIT]      = strap_s2_r;
    hw_word[TXC_TMODE_BIT]      = tmode_r;
    hw_word[TXC_BWF_BIT]        = bwf_r;
    hw_word[TXC_SIZE_LSB +: 4]  = size_r;
  end

  always_comb
  begin
    alloc_word                  = 32'h0000_0000;
    alloc_word[14:0]            = txd_bytes;
    alloc_word[30:16]           = rx_bytes;
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_bus.addr)
      TXC_TX_CTRL_OFS: rdata_nxt      = ctrl_word;
      TXC_HARDWARE_CONFIGURATION_OFS:  rdata_nxt      = hw_word;
      TXC_INT_STS_OFS: rdata_nxt[2:0] = sts_r;
      TXC_INT_MSK_OFS: rdata_nxt[2:0] = msk_r;
      TXC_ALLOC_OFS:   rdata_nxt      = alloc_word;
      default:         rdata_nxt      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      o_rdata <= 32'h0000_0000;
    else if (i_bus.rd)
      o_rdata <= rdata_nxt;
    else
      o_rdata <= 32'h0000_0000;
  end

endmodule : txc_ctrl

`default_nettype wire

/* File: txc_ctrl_assertions.sv */
// Checker bound to the transmit control block ports.
// Assumes bus strobes stay low while reset is held.
`timescale 1ns/1ps
`default_nettype none
module txc_ctrl_assertions
(
  // Clock, reset and host port
  input wire logic                  i_core_clk,
  input wire logic                  i_srst,
  input wire txc_pkg::txc_bus_req_t i_bus,
  input wire logic [31:0]           o_rdata,
  // Engine side
  input wire txc_pkg::txc_eng_t     i_eng,
  input wire txc_pkg::txc_ctl_t     o_ctl
);
  import txc_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  a_status_discard: assert property (
    o_ctl.sdiscard == ($past(i_bus.wr) && $past(i_bus.addr) == TXC_TX_CTRL_OFS
                       && $past(i_bus.wdata[15]))) else $error("status discard pulse wrong");
  a_data_discard: assert property (
    o_ctl.ddiscard == ($past(i_bus.wr) && $past(i_bus.addr) == TXC_TX_CTRL_OFS
                       && $past(i_bus.wdata[14]))) else $error("data discard pulse wrong");
  a_status_share: assert property (
    !$past(i_srst) && !$past(i_srst, 2) |-> o_ctl.tx_bytes - o_ctl.txd_bytes == TXC_STS_BYTES)
    else $error("status share wrong");
  a_rx_share: assert property (
    !$past(i_srst) && !$past(i_srst, 2) |-> o_ctl.rx_bytes + o_ctl.tx_bytes == TXC_TOTAL_BYTES)
    else $error("rx share wrong");
  a_ctrl_reserved: assert property (
    $past(i_bus.rd) && $past(i_bus.addr) == TXC_TX_CTRL_OFS
    |-> o_rdata[31:14] == 18'h0 && o_rdata[11:3] == 9'h0) else $error("ctrl reserved bits set");
  a_hw_reserved: assert property (
    $past(i_bus.rd) && $past(i_bus.addr) == TXC_HARDWARE_CONFIGURATION_OFS |-> o_rdata[31:25] == 7'h0
    && o_rdata[23:22] == 2'h0 && o_rdata[15:0] == 16'h0) else $error("hw reserved bits set");
  a_stop_clear: assert property (
    o_ctl.stop_req && i_eng.halted |-> ##[1:4] !o_ctl.stop_req && !o_ctl.run)
    else $error("stop not cleared after halt");
  a_stop_hold: assert property (
    o_ctl.stop_req && !i_eng.halted && !$past(i_eng.halted) |=> o_ctl.stop_req)
    else $error("stop dropped before halt");
endmodule : txc_ctrl_assertions

bind txc_ctrl txc_ctrl_assertions txc_ctrl_assertions_inst (.i_core_clk(i_core_clk),
  .i_srst(i_srst), .i_bus(i_bus), .o_rdata(o_rdata), .i_eng(i_eng), .o_ctl(o_ctl));
`default_nettype wire

/* File: txc_engine_model.sv */
// Transmit engine stand-in: ends the current frame, then reports halted.
// Assumes the bench supplies the FIFO-side fields through i_fifo.
`timescale 1ns/1ps
`default_nettype none
module txc_engine_model
#(
  parameter int FRAME_CYCLES = 8
)
(
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  // Block side
  input  wire txc_pkg::txc_ctl_t i_ctl,
  input  wire txc_pkg::txc_eng_t i_fifo,
  output var txc_pkg::txc_eng_t  o_eng
);
  import txc_pkg::*;
  logic [7:0] left_r;
  logic       halted_r;
  // Halt stays up until the block runs again without a stop pending
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst || (i_ctl.run && !i_ctl.stop_req))
    begin
      left_r   <= 8'(FRAME_CYCLES);
      halted_r <= 1'b0;
    end
    else if (i_ctl.stop_req && left_r != 8'h0)
      left_r <= left_r - 8'h1;
    else if (i_ctl.stop_req)
      halted_r <= 1'b1;
  end
  always_comb
  begin
    o_eng        = i_fifo;
    o_eng.halted = halted_r;
  end
endmodule : txc_engine_model
`default_nettype wire

/* File: tb_tx_control_and_fifo_config.sv */
// Self-checking bench for the transmit control block.
// Assumes the engine stand-in; the strap pin is held high.
`timescale 1ns/1ps
`default_nettype none
module tb_tx_control_and_fifo_config;
  import txc_pkg::*;
  logic                  clk;
  logic                  srst;
  logic                  strap;
  logic                  irq;
  logic [31:0]           rdata;
  txc_bus_req_t          bus;
  txc_eng_t              fifo;
  txc_eng_t              eng;
  txc_ctl_t              ctl;
  int                    mismatches;
  int                    num_checks;
  int                    k;
  logic [7:0]            lvl [4] = '{TXC_LVL0, TXC_LVL1, TXC_LVL2, TXC_LVL3};

  txc_ctrl txc_ctrl_inst (.i_core_clk(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata),
    .i_crossover_strap(strap), .i_eng(eng), .o_ctl(ctl), .o_irq(irq));
  txc_engine_model txc_engine_model_inst (.i_core_clk(clk), .i_srst(srst), .i_ctl(ctl),
    .i_fifo(fifo), .o_eng(eng));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask : rd

  // Sets the FIFO-side view, then lets the registered outputs settle
  task automatic eng_set(input logic [7:0] dw, input logic whole, full, under);
    @(posedge clk);
    fifo.data_dwords <= dw;
    fifo.frame_whole <= whole;
    fifo.sts_full    <= full;
    fifo.underrun    <= under;
    repeat (3) @(posedge clk);
    #1;
  endtask : eng_set

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    strap = 1'b1;
    bus = '0;
    fifo = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // Strap needs two synchroniser stages before it reads back
    repeat (2) @(posedge clk);
    rd(TXC_HARDWARE_CONFIGURATION_OFS, 32'h0105_0000);
    rd(TXC_ALLOC_OFS, 32'h2c00_1200);
    rd(8'h90, 32'h0);
    wr(TXC_HARDWARE_CONFIGURATION_OFS, 32'h0002_0000);
    rd(TXC_ALLOC_OFS, 32'h3800_0600);
    wr(TXC_HARDWARE_CONFIGURATION_OFS, 32'hfefe_ffff);
    rd(TXC_HARDWARE_CONFIGURATION_OFS, 32'h013e_0000);
    rd(TXC_ALLOC_OFS, 32'h0800_3600);
    wr(TXC_TX_CTRL_OFS, 32'hffff_cff8);
    rd(TXC_TX_CTRL_OFS, 32'h0);
    eng_set(8'hff, 1'b0, 1'b0, 1'b0);
    chk("go", 32'h0, {31'h0, ctl.go});
    eng_set(8'hff, 1'b1, 1'b0, 1'b0);
    chk("go", 32'h1, {31'h0, ctl.go});
    wr(TXC_HARDWARE_CONFIGURATION_OFS, 32'h0025_0000);
    for (k = 0; k < 4; k++)
    begin
      wr(TXC_TX_CTRL_OFS, 32'(k) << 12);
      eng_set(lvl[k] - 8'h1, 1'b0, 1'b0, 1'b0);
      chk("go", 32'h0, {31'h0, ctl.go});
      eng_set(lvl[k], 1'b0, 1'b0, 1'b0);
      chk("go", 32'h1, {31'h0, ctl.go});
    end
    wr(TXC_HARDWARE_CONFIGURATION_OFS, 32'h0005_0000);
    eng_set(8'h1, 1'b0, 1'b0, 1'b1);
    chk("go", 32'h1, {31'h0, ctl.go});
    rd(TXC_INT_STS_OFS, 32'h2);
    wr(TXC_TX_CTRL_OFS, 32'h2);
    eng_set(8'h0, 1'b0, 1'b0, 1'b0);
    chk("run", 32'h1, {31'h0, ctl.run});
    // Underrun was still high at the last clearing read
    rd(TXC_INT_STS_OFS, 32'h2);
    eng_set(8'h0, 1'b0, 1'b1, 1'b0);
    chk("run", 32'h0, {31'h0, ctl.run});
    chk("irq", 32'h0, {31'h0, irq});
    rd(TXC_INT_STS_OFS, 32'h1);
    wr(TXC_INT_MSK_OFS, 32'h1);
    wr(TXC_TX_CTRL_OFS, 32'h6);
    eng_set(8'h0, 1'b0, 1'b0, 1'b0);
    eng_set(8'h0, 1'b0, 1'b1, 1'b0);
    chk("run", 32'h1, {31'h0, ctl.run});
    chk("irq", 32'h1, {31'h0, irq});
    rd(TXC_INT_STS_OFS, 32'h1);
    eng_set(8'h0, 1'b0, 1'b0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(TXC_TX_CTRL_OFS, 32'h7);
    wr(TXC_TX_CTRL_OFS, 32'h6);
    rd(TXC_TX_CTRL_OFS, 32'h7);
    k = 0;
    while (ctl.stop_req !== 1'b0 && k < 60)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 60)
    begin
      mismatches++;
      tally_and_finish();
    end
    rd(TXC_TX_CTRL_OFS, 32'h4);
    rd(TXC_INT_STS_OFS, 32'h4);
    tally_and_finish();
  end
endmodule : tb_tx_control_and_fifo_config
`default_nettype wire
